/* wwdt_pkg.sv */
`default_nettype none
package wwdt_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0] CTRL_INDEX   = 4'h0;
  localparam logic [3:0] STATUS_INDEX = 4'h1;
  // Control register fields
  localparam int         PERIOD_LSB   = 0;
  localparam int         WINDOW_LSB   = 4;
  localparam int         FIELD_W      = 4;
  localparam logic [3:0] CODE_OFF     = 4'h0;
  localparam logic [3:0] CODE_MAX     = 4'hb;
  // Status register fields
  localparam int         LOCK_BIT     = 7;
  localparam int         BUSY_BIT     = 0;
  // Reset values before the fuse image is loaded
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic       LOCK_RESET   = 1'b0;
  // Counter timing: shortest period in microseconds and counter clock rate
  localparam int         WD_CLOCK_HZ  = 1000;
  localparam int         BASE_TIME_US = 8000;
  localparam int         CNT_W        = 14;
  localparam logic [CNT_W-1:0] BASE_CYCLES =
    CNT_W'(BASE_TIME_US * WD_CLOCK_HZ / 1000000);

  typedef enum logic [2:0] {
    WWDT_OFF    = 3'b000,
    WWDT_NORMAL = 3'b001,
    WWDT_FIRST  = 3'b010,
    WWDT_CLOSED = 3'b011,
    WWDT_OPEN   = 3'b100
  } wwdt_state_t;
endpackage : wwdt_pkg
`default_nettype wire

/* wwdt_top.sv */
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Non-zero period code enables the watchdog; zero keeps it off.
// - Non-zero window code selects window mode; zero returns to normal mode.
// - Normal mode: no clear before the period ends issues system reset.
// - Every accepted clear restarts the counter: a full period in normal mode, a closed period in window mode.
// - Eleven period settings from 8 ms to 8 s.
// - Window mode: a clear during the closed period issues system reset.
// - Open period follows closed; clear only when open; open expiry resets.
// - After enabling window mode or debug halt, closed period waits first clear.
// - A clear arriving while a previous clear still crosses is ignored.
// - With lock set, control register writes are rejected.
// - Software only sets lock; clearing it works only in debug mode.
// - Control reset value comes from fuse; non-zero period sets lock.
// - Counter runs on the independent 1 kHz watchdog clock.
// - Control writes reach the counter domain only through synchronisation.
// - Counting continues in sleep and without the system clock.
// - Busy flag shows while a control write crosses; no control writes meanwhile.
// - Codes 1 to 11 give 8 to 8K cycles, doubling per step.
// - Debug halt resets the counter and pauses counting.
module wwdt_top #(
  parameter logic [13:0] BASE_CYCLES = wwdt_pkg::BASE_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [3:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        wdClock,
  input  wire logic        timedWriteOpen,
  input  wire logic        watchdogClearInstruction,
  input  wire logic        debugHalt,
  input  wire logic        debugMode,
  input  wire logic [7:0]  watchdogConfigFuse,
  output logic             systemResetRequest
);

  // System clock domain state
  logic [7:0]  ctrl_reg,       ctrl_next;
  logic        lock_reg,       lock_next;
  logic        fuseDone_reg,   fuseDone_next;
  logic        reqToggle_reg,  reqToggle_next;
  logic        clrToggle_reg,  clrToggle_next;
  logic [1:0]  reqAck_reg,     reqAck_next;
  logic [1:0]  clrAck_reg,     clrAck_next;
  logic [31:0] prdata_reg,     prdata_next;
  // Watchdog clock domain state
  logic [2:0]  reqSync_reg,    reqSync_next;
  logic [2:0]  clrSync_reg,    clrSync_next;
  logic [2:0]  haltSync_reg,   haltSync_next;
  logic        haltLvl_reg,    haltLvl_next;
  logic [7:0]  ctrlWd_reg,     ctrlWd_next;
  wwdt_pkg::wwdt_state_t state_reg, state_next;
  logic [13:0] cnt_reg,        cnt_next;
  logic        resetReq_reg,   resetReq_next;

  logic        sync_in_progress_flag;
  logic        clrBusy;
  logic        addrOk;
  logic        isCtrl;
  logic        isStatus;
  logic        accessWrite;
  logic        loadCtrl;
  logic        clrEvent;
  logic [3:0]  perCode;
  logic [3:0]  winCode;
  logic [13:0] openLim;
  logic [13:0] closedLim;

  function automatic logic [13:0] wwdtLimit(input logic [3:0] code,
                                            input logic [13:0] base);
    logic [3:0] c;
    c = (code > wwdt_pkg::CODE_MAX) ? wwdt_pkg::CODE_MAX : code;
    wwdtLimit = (base << (c - 4'h1)) - 14'h1;
  endfunction : wwdtLimit

  assign isCtrl      = (paddr[3:2] == wwdt_pkg::CTRL_INDEX[1:0]);
  assign isStatus    = (paddr[3:2] == wwdt_pkg::STATUS_INDEX[1:0]);
  assign addrOk      = (paddr[1:0] == 2'h0) && (isCtrl || isStatus);
  assign accessWrite = psel && penable && pwrite && addrOk;
  // busy while the write handshake is open
  assign sync_in_progress_flag    = reqToggle_reg ^ reqAck_reg[1];
  assign clrBusy     = clrToggle_reg ^ clrAck_reg[1];

  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !addrOk;
  assign prdata      = prdata_reg;

  always_comb begin
    ctrl_next      = ctrl_reg;
    lock_next      = lock_reg;
    fuseDone_next  = 1'b1;
    reqToggle_next = reqToggle_reg;
    clrToggle_next = clrToggle_reg;
    reqAck_next    = {reqAck_reg[0], reqSync_reg[2]};
    clrAck_next    = {clrAck_reg[0], clrSync_reg[2]};
    prdata_next    = prdata_reg;
    if (!fuseDone_reg) begin
      // fuse image loaded after reset release
      ctrl_next      = watchdogConfigFuse;
      lock_next      = (watchdogConfigFuse[3:0] != wwdt_pkg::CODE_OFF);
      reqToggle_next = !reqToggle_reg;
    end else if (accessWrite && isCtrl && timedWriteOpen) begin
      if (!lock_reg && !sync_in_progress_flag) begin
        ctrl_next      = pwdata[7:0];
        reqToggle_next = !reqToggle_reg;
      end
    end else if (accessWrite && isStatus && timedWriteOpen) begin
      if (pwdata[wwdt_pkg::LOCK_BIT]) begin
        lock_next = 1'b1;
      end else if (debugMode) begin
        lock_next = 1'b0;
      end
    end
    if (watchdogClearInstruction && !clrBusy) begin
      clrToggle_next = !clrToggle_reg;
    end
    if (psel && !penable) begin
      prdata_next = 32'h0000_0000;
      if (addrOk && isCtrl) begin
        prdata_next[7:0] = ctrl_reg;
      end else if (addrOk && isStatus) begin
        prdata_next[wwdt_pkg::LOCK_BIT] = lock_reg;
        prdata_next[wwdt_pkg::BUSY_BIT] = sync_in_progress_flag;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg      <= wwdt_pkg::CTRL_RESET;
      lock_reg      <= wwdt_pkg::LOCK_RESET;
      fuseDone_reg  <= 1'b0;
      reqToggle_reg <= 1'b0;
      clrToggle_reg <= 1'b0;
      reqAck_reg    <= 2'h0;
      clrAck_reg    <= 2'h0;
      prdata_reg    <= 32'h0000_0000;
    end else begin
      ctrl_reg      <= ctrl_next;
      lock_reg      <= lock_next;
      fuseDone_reg  <= fuseDone_next;
      reqToggle_reg <= reqToggle_next;
      clrToggle_reg <= clrToggle_next;
      reqAck_reg    <= reqAck_next;
      clrAck_reg    <= clrAck_next;
      prdata_reg    <= prdata_next;
    end
  end

  // Counter domain synchronisers and control copy
  always_comb begin
    reqSync_next  = {reqSync_reg[1:0], reqToggle_reg};
    clrSync_next  = {clrSync_reg[1:0], clrToggle_reg};
    haltSync_next = {haltSync_reg[1:0], debugHalt};
    haltLvl_next  = haltLvl_reg;
    if (haltSync_reg[1] == haltSync_reg[2]) begin
      haltLvl_next = haltSync_reg[2];
    end
    ctrlWd_next = ctrlWd_reg;
    // ctrl_reg is stable while the handshake is open
    if (loadCtrl) begin
      ctrlWd_next = ctrl_reg;
    end
  end

  assign loadCtrl  = reqSync_reg[1] ^ reqSync_reg[2];
  assign clrEvent  = clrSync_reg[1] ^ clrSync_reg[2];
  assign perCode   = ctrlWd_reg[wwdt_pkg::PERIOD_LSB +: wwdt_pkg::FIELD_W];
  assign winCode   = ctrlWd_reg[wwdt_pkg::WINDOW_LSB +: wwdt_pkg::FIELD_W];
  assign openLim   = wwdtLimit(perCode, BASE_CYCLES);
  assign closedLim = wwdtLimit(winCode, BASE_CYCLES);

  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg + 14'h1;
    resetReq_next = 1'b0;
    if (perCode == wwdt_pkg::CODE_OFF) begin
      state_next = wwdt_pkg::WWDT_OFF;
      cnt_next   = 14'h0;
    end else if (haltLvl_reg) begin
      cnt_next   = 14'h0;
      state_next = (winCode != wwdt_pkg::CODE_OFF) ? wwdt_pkg::WWDT_FIRST
                                                   : wwdt_pkg::WWDT_NORMAL;
    end else begin
      case (state_reg)
        wwdt_pkg::WWDT_OFF: begin
          cnt_next   = 14'h0;
          state_next = (winCode != wwdt_pkg::CODE_OFF) ? wwdt_pkg::WWDT_FIRST
                                                       : wwdt_pkg::WWDT_NORMAL;
        end
        wwdt_pkg::WWDT_NORMAL: begin
          if (winCode != wwdt_pkg::CODE_OFF) begin
            state_next = wwdt_pkg::WWDT_FIRST;
            cnt_next   = 14'h0;
          end else if (clrEvent) begin
            cnt_next = 14'h0;
          end else if (cnt_reg >= openLim) begin
            resetReq_next = 1'b1;
            cnt_next      = 14'h0;
          end
        end
        wwdt_pkg::WWDT_FIRST: begin
          if (winCode == wwdt_pkg::CODE_OFF) begin
            state_next = wwdt_pkg::WWDT_NORMAL;
            cnt_next   = 14'h0;
          end else if (clrEvent) begin
            state_next = wwdt_pkg::WWDT_CLOSED;
            cnt_next   = 14'h0;
          end else if (cnt_reg >= openLim) begin
            resetReq_next = 1'b1;
            cnt_next      = 14'h0;
          end
        end
        wwdt_pkg::WWDT_CLOSED: begin
          if (winCode == wwdt_pkg::CODE_OFF) begin
            state_next = wwdt_pkg::WWDT_NORMAL;
            cnt_next   = 14'h0;
          end else if (clrEvent) begin
            resetReq_next = 1'b1;
            cnt_next      = 14'h0;
          end else if (cnt_reg >= closedLim) begin
            state_next = wwdt_pkg::WWDT_OPEN;
            cnt_next   = 14'h0;
          end
        end
        wwdt_pkg::WWDT_OPEN: begin
          if (winCode == wwdt_pkg::CODE_OFF) begin
            state_next = wwdt_pkg::WWDT_NORMAL;
            cnt_next   = 14'h0;
          end else if (clrEvent) begin
            state_next = wwdt_pkg::WWDT_CLOSED;
            cnt_next   = 14'h0;
          end else if (cnt_reg >= openLim) begin
            resetReq_next = 1'b1;
            state_next    = wwdt_pkg::WWDT_CLOSED;
            cnt_next      = 14'h0;
          end
        end
        default: begin
          state_next = wwdt_pkg::WWDT_OFF;
          cnt_next   = 14'h0;
        end
      endcase
    end
  end

  // counter domain on the 1 kHz clock
  always_ff @(posedge wdClock or negedge rst_n) begin
    if (!rst_n) begin
      reqSync_reg  <= 3'h0;
      clrSync_reg  <= 3'h0;
      haltSync_reg <= 3'h0;
      haltLvl_reg  <= 1'b0;
      ctrlWd_reg   <= wwdt_pkg::CTRL_RESET;
      state_reg    <= wwdt_pkg::WWDT_OFF;
      cnt_reg      <= 14'h0;
      resetReq_reg <= 1'b0;
    end else begin
      reqSync_reg  <= reqSync_next;
      clrSync_reg  <= clrSync_next;
      haltSync_reg <= haltSync_next;
      haltLvl_reg  <= haltLvl_next;
      ctrlWd_reg   <= ctrlWd_next;
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      resetReq_reg <= resetReq_next;
    end
  end

  assign systemResetRequest = resetReq_reg;

endmodule : wwdt_top
`default_nettype wire

/* wwdt_top_props.sv */
`timescale 1ns/1ns
`default_nettype none
module wwdt_top_props #(
  parameter logic [13:0] BASE_CYCLES = 14'h0002
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [3:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        wdClock,
  input wire logic        debugHalt,
  input wire logic        debugMode,
  input wire logic        systemResetRequest
);
  logic       lockSeen_reg, lockSeen_next, ctrlSeen_reg, ctrlSeen_next;
  logic [7:0] ctrlVal_reg, ctrlVal_next;
  logic       rdSt, rdCt;
  assign rdSt = psel && penable && !pwrite && paddr == 4'h4;
  assign rdCt = psel && penable && !pwrite && paddr == 4'h0;
  // Remember a lock once seen, and the control value read under it
  always_comb begin
    lockSeen_next = lockSeen_reg || (rdSt && prdata[7]);
    if (psel && penable && pwrite && paddr == 4'h4 && debugMode) lockSeen_next = 1'b0;
    ctrlSeen_next = lockSeen_next && (ctrlSeen_reg || (rdCt && lockSeen_reg));
    ctrlVal_next = (rdCt && !ctrlSeen_reg) ? prdata[7:0] : ctrlVal_reg;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lockSeen_reg <= 1'b0;
      ctrlSeen_reg <= 1'b0;
      ctrlVal_reg <= 8'h00;
    end else begin
      lockSeen_reg <= lockSeen_next;
      ctrlSeen_reg <= ctrlSeen_next;
      ctrlVal_reg <= ctrlVal_next;
    end
  end
  AST_RESET_PULSE: assert property (@(posedge wdClock) disable iff (!rst_n)
    $rose(systemResetRequest) |=> !systemResetRequest) else $error("reset pulse too long");
  AST_HALT_QUIET: assert property (@(posedge wdClock) disable iff (!rst_n)
    debugHalt [*8] |-> !systemResetRequest) else $error("reset during debug halt");
  AST_LOCK_STICKY: assert property (@(posedge clock) disable iff (!rst_n)
    rdSt && lockSeen_reg |-> prdata[7]) else $error("lock cleared outside debug");
  AST_CTRL_FROZEN: assert property (@(posedge clock) disable iff (!rst_n)
    rdCt && ctrlSeen_reg |-> prdata[7:0] == ctrlVal_reg) else $error("control changed under lock");
  AST_UPPER_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
    psel && penable |-> prdata[31:8] == 24'h0) else $error("upper read bits not zero");
  AST_UNMAPPED: assert property (@(posedge clock) disable iff (!rst_n)
    psel && penable && paddr[3] |-> pslverr) else $error("unmapped access not flagged");
  AST_ERR_ACCESS: assert property (@(posedge clock) disable iff (!rst_n)
    pslverr |-> psel && penable) else $error("error outside access phase");
  AST_READ_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    psel && penable && !pwrite |=> $stable(prdata)) else $error("read data not held");
  cover property (@(posedge wdClock) $rose(systemResetRequest));
  cover property (@(posedge clock) rdCt && ctrlSeen_reg);
  cover property (@(posedge clock) pslverr);
endmodule : wwdt_top_props
bind wwdt_top wwdt_top_props #(.BASE_CYCLES(BASE_CYCLES)) props (.clock(clock), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pslverr(pslverr), .wdClock(wdClock), .debugHalt(debugHalt), .debugMode(debugMode),
  .systemResetRequest(systemResetRequest));
`default_nettype wire

/* wwdt_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module wwdt_cpu_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic unlockReq,
  input wire logic clearReq,
  output logic     timedWriteOpen,
  output logic     clearPulse
);
  logic [2:0] open_reg, open_next;
  logic       clr_reg, clr_next;
  always_comb begin
    open_next = unlockReq ? 3'h4 : (open_reg != 3'h0 ? open_reg - 3'h1 : 3'h0);
    clr_next = clearReq;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      open_reg <= 3'h0;
      clr_reg <= 1'b0;
    end else begin
      open_reg <= open_next;
      clr_reg <= clr_next;
    end
  end
  assign timedWriteOpen = open_reg != 3'h0;
  assign clearPulse = clr_reg;
endmodule : wwdt_cpu_model
`default_nettype wire

/* test_windowed_watchdog_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module test_windowed_watchdog_timer;
  logic        clock, rst_n, psel, penable, pwrite, wdClock, debugHalt, debugMode, err;
  logic        unlockReq, clearReq, timedWriteOpen, clearPulse, pready, pslverr, sysRst;
  logic [3:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  fuse;
  int          failCount, samplesChecked, rstCount, k, base;
  wwdt_top #(.BASE_CYCLES(14'h0002)) dut (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wdClock(wdClock), .timedWriteOpen(timedWriteOpen),
    .watchdogClearInstruction(clearPulse), .debugHalt(debugHalt), .debugMode(debugMode),
    .watchdogConfigFuse(fuse), .systemResetRequest(sysRst));
  wwdt_cpu_model cpu (.clock(clock), .rst_n(rst_n), .unlockReq(unlockReq),
    .clearReq(clearReq), .timedWriteOpen(timedWriteOpen), .clearPulse(clearPulse));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    wdClock = 1'b0;
    #7;
    forever #185 wdClock = ~wdClock;
  end
  always @(negedge wdClock) if (sysRst === 1'b1) rstCount++;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samplesChecked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      failCount++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pw(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock) unlockReq <= 1'b1;
    @(posedge clock) unlockReq <= 1'b0;
    apb(1'b1, a, d);
  endtask : pw
  task automatic clr;
    @(posedge clock) clearReq <= 1'b1;
    @(posedge clock) clearReq <= 1'b0;
  endtask : clr
  task automatic wd(input int n);
    repeat (n) @(posedge wdClock);
  endtask : wd
  task automatic idle;
    k = 0;
    do begin
      apb(1'b0, 4'h4, 32'h0);
      k++;
    end while (r[0] !== 1'b0 && k < 100);
    chk("sync busy", 32'h0, {31'h0, r[0]});
  endtask : idle
  task automatic lat(input int lo, input int hi, input string nm);
    k = 0;
    while (sysRst !== 1'b1 && k <= hi) begin
      @(negedge wdClock);
      k++;
    end
    chk(nm, 32'h1, {31'h0, k >= lo && k <= hi});
  endtask : lat
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    #1000000;
    failCount++;
    summarize;
  end
  initial begin
    {rst_n, psel, penable, pwrite, debugHalt, debugMode, unlockReq, clearReq} = 8'h00;
    {paddr, pwdata, fuse} = 44'h0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    apb(1'b0, 4'h0, 32'h0);
    chk("fuse ctrl zero", 32'h0, r);
    chk("mapped no error", 32'h0, {31'h0, err});
    apb(1'b1, 4'h0, 32'h3);
    apb(1'b0, 4'h0, 32'h0);
    chk("unprotected", 32'h0, r);
    apb(1'b0, 4'h8, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    wd(20);
    chk("off no reset", 32'h0, rstCount);
    pw(4'h0, 32'h3);
    apb(1'b0, 4'h0, 32'h0);
    chk("ctrl write", 32'h3, r);
    idle;
    repeat (5) begin
      clr;
      wd(5);
    end
    chk("cleared in time", 32'h0, rstCount);
    clr;
    lat(9, 13, "normal timeout");
    pw(4'h0, 32'h33);
    idle;
    // Let a pulse launched under the old setting be counted first
    wd(1);
    base = rstCount;
    clr;
    wd(12);
    clr;
    wd(12);
    clr;
    clr;
    chk("open clears", base, rstCount);
    lat(17, 22, "open expiry");
    wd(3);
    clr;
    lat(1, 6, "closed clear");
    pw(4'h4, 32'h80);
    apb(1'b0, 4'h4, 32'h0);
    chk("lock set", 32'h80, r);
    pw(4'h0, 32'h0);
    apb(1'b0, 4'h0, 32'h0);
    chk("locked ctrl", 32'h33, r);
    pw(4'h4, 32'h0);
    apb(1'b0, 4'h4, 32'h0);
    chk("lock kept", 32'h80, r);
    pw(4'h0, 32'h05);
    apb(1'b0, 4'h0, 32'h0);
    chk("locked ctrl again", 32'h33, r);
    debugMode <= 1'b1;
    pw(4'h4, 32'h0);
    apb(1'b0, 4'h4, 32'h0);
    chk("debug unlock", 32'h0, r);
    debugMode <= 1'b0;
    debugHalt <= 1'b1;
    wd(8);
    base = rstCount;
    wd(40);
    chk("halted", base, rstCount);
    pw(4'h0, 32'h0);
    idle;
    debugHalt <= 1'b0;
    wd(30);
    chk("disabled", base, rstCount);
    @(posedge clock) rst_n <= 1'b0;
    fuse <= 8'h02;
    wd(2);
    @(posedge clock) rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    apb(1'b0, 4'h0, 32'h0);
    chk("fuse ctrl", 32'h2, r);
    apb(1'b0, 4'h4, 32'h0);
    chk("fuse lock", 32'h1, {31'h0, r[7]});
    clr;
    lat(7, 9, "short period timeout");
    summarize;
  end
endmodule : test_windowed_watchdog_timer
`default_nettype wire
